/* pis_sequencer.sv */
`timescale 1ns/1ps
`include "pis_defines.svh"

module pis_sequencer import pis_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // engine position from the tracker, in degrees of the 720 cycle
    input wire logic [9:0] crank_angle,
    input wire logic cycle_start,
    input wire logic [15:0] engine_rpm,
    // time-mode trigger event
    input wire logic trigger_event,
    // injector commands
    output pis_cmd_t port_injector_channel
);
    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    logic mode_reg;
    logic ang_en_reg;
    logic tim_en_reg;
    logic [3:0] skip_cycle_enable;
    logic [9:0] injection_start_angle;
    logic [15:0] delay_us_reg;
    logic [7:0] skip_period_length;
    logic [7:0] active_cycle_count;
    logic [15:0] rpm_reg;
    logic [3:0] manual_single_trigger;
    logic [9:0] top_dead_centre [4];
    logic [15:0] dur_us_reg [4];
    logic [15:0] crank_angle_degrees [4];
    logic [3:0] busy;
    logic [3:0] cmd;
    logic [3:0] start;
    logic [7:0] skip_cnt_reg [4];
    logic [7:0] act_clamped;
    logic [9:0] fire_angle [4];
    logic [9:0] angle_prev_reg;
    logic trig_reg;
    logic trig_prev_reg;
    logic trig_meta_reg;
    logic trig_rise;
    logic [3:0] angle_hit_vec;
    logic [3:0] drive_en;
    logic [23:0] delay_cyc;
    logic [23:0] dur_cyc [4];

    // index decode of the per-channel register banks
    function automatic logic bank_hit(input logic [7:0] a, input logic [7:0] base, input logic [1:0] ch);
        bank_hit = (a == (base + {4'h0, ch, 2'b00}));
    endfunction : bank_hit

    // microseconds into clock cycles
    function automatic logic [23:0] us_to_cyc(input logic [15:0] us);
        us_to_cyc = 24'(us) * 24'(`PIS_CYC_PER_US);
    endfunction : us_to_cyc

    // ------------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------------
    // shared control fields
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mode_reg <= 1'b0;
            ang_en_reg <= 1'b0;
            tim_en_reg <= 1'b0;
            skip_cycle_enable <= 4'h0;
            injection_start_angle <= 10'h000;
            delay_us_reg <= 16'h0000;
            skip_period_length <= `PIS_RST_SKIP_PERIOD;
            active_cycle_count <= `PIS_RST_SKIP_ACTIVE;
        end else if (wr) begin
            case (addr)
                `PIS_OFF_CTRL: begin
                    mode_reg <= wdata[`PIS_CTRL_MODE_BIT];
                    ang_en_reg <= wdata[`PIS_CTRL_ANG_EN_BIT];
                    tim_en_reg <= wdata[`PIS_CTRL_TIM_EN_BIT];
                    skip_cycle_enable <= wdata[`PIS_CTRL_SKIP_LSB +: 4];
                end
                `PIS_OFF_ANGLE: injection_start_angle <= wdata[9:0];
                `PIS_OFF_DELAY: delay_us_reg <= wdata[15:0];
                `PIS_OFF_SKIP: begin
                    // period minimum of one
                    skip_period_length <= (wdata[7:0] == 8'h00) ? 8'h01 : wdata[7:0];
                    active_cycle_count <= wdata[`PIS_SKIP_ACT_LSB +: 8];
                end
                default: begin
                end
            endcase
        end
    end

    // engine speed sampled each cycle for the degree conversion
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rpm_reg <= 16'h0000;
        end else begin
            rpm_reg <= engine_rpm;
        end
    end

    // manual single-shot triggers: one pulse per write of a one bit
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            manual_single_trigger <= 4'h0;
        end else begin
            manual_single_trigger <= (wr && addr == `PIS_OFF_TRIG) ? wdata[3:0] : 4'h0;
        end
    end

    // clamp the active count into 1..period
    always_comb begin
        if (active_cycle_count == 8'h00) begin
            act_clamped = 8'h01;
        end else if (active_cycle_count > skip_period_length) begin
            act_clamped = skip_period_length;
        end else begin
            act_clamped = active_cycle_count;
        end
    end

    // ------------------------------------------------------------------------
    // edge detection of position and trigger
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            angle_prev_reg <= 10'h000;
            trig_meta_reg <= 1'b0;
            trig_reg <= 1'b0;
            trig_prev_reg <= 1'b0;
        end else begin
            angle_prev_reg <= crank_angle;
            trig_meta_reg <= trigger_event; // pin synchroniser, first stage
            trig_reg <= trig_meta_reg;
            trig_prev_reg <= trig_reg;
        end
    end

    assign delay_cyc = us_to_cyc(delay_us_reg);

    // rising edge of the synchronised trigger
    assign trig_rise = trig_reg && !trig_prev_reg;

    // ------------------------------------------------------------------------
    // per-channel logic
    // ------------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_ch
            logic angle_hit;
            logic skip_fire;

            // per-channel bank writes
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    top_dead_centre[g] <= 10'h000;
                    dur_us_reg[g] <= 16'h0000;
                end else if (wr) begin
                    if (bank_hit(addr, `PIS_OFF_TOP0, 2'(g))) begin
                        top_dead_centre[g] <= wdata[9:0];
                    end
                    if (bank_hit(addr, `PIS_OFF_DUR0, 2'(g))) begin
                        dur_us_reg[g] <= wdata[15:0];
                    end
                end
            end

            // start angle is the cylinder's top centre minus the advance
            always_comb begin
                if (top_dead_centre[g] >= injection_start_angle) begin
                    fire_angle[g] = top_dead_centre[g] - injection_start_angle;
                end else begin
                    fire_angle[g] = 10'(top_dead_centre[g] + 10'(`PIS_DEG_PER_CYCLE) - injection_start_angle);
                end
            end

            // crossing of the start angle on this sample
            assign angle_hit = (crank_angle == fire_angle[g]) && (angle_prev_reg != fire_angle[g]);
            assign angle_hit_vec[g] = angle_hit;

            // skip counter counts engine cycles within the period
            always_ff @(posedge clk) begin
                if (!rst_b || !skip_cycle_enable[g]) begin
                    skip_cnt_reg[g] <= 8'h00;
                end else if (cycle_start) begin
                    if (skip_cnt_reg[g] + 8'h01 >= skip_period_length) begin
                        skip_cnt_reg[g] <= 8'h00;
                    end else begin
                        skip_cnt_reg[g] <= skip_cnt_reg[g] + 8'h01;
                    end
                end
            end

            // fire in the first active cycles only
            assign skip_fire = !skip_cycle_enable[g] || (skip_cnt_reg[g] < act_clamped);

            // launch from the selected mode only
            assign start[g] = (mode_reg == PIS_MODE_ANGLE) ? angle_hit
                : (manual_single_trigger[g] || trig_rise);
            assign dur_cyc[g] = us_to_cyc(dur_us_reg[g]);

            // angle slots obey enable and skip pattern, time slots only the enable
            assign drive_en[g] = (mode_reg == PIS_MODE_ANGLE) ? (ang_en_reg && skip_fire)
                : tim_en_reg;

            pis_channel pis_channel_inst (
                .clk(clk),
                .rst_b(rst_b),
                .start(start[g]),
                .delay_cyc((mode_reg == PIS_MODE_ANGLE) ? 24'h000000 : delay_cyc),
                .dur_cyc(dur_cyc[g]),
                .drive_en(drive_en[g]),
                .cmd(cmd[g]),
                .busy(busy[g])
            );

            pis_deg_calc pis_deg_calc_inst (
                .clk(clk),
                .rst_b(rst_b),
                .dur_us(dur_us_reg[g]),
                .rpm(rpm_reg),
                .deg_tenths(crank_angle_degrees[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    // the four injector commands, each with its own duration register; no low-side outputs
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            port_injector_channel <= '0;
        end else begin
            port_injector_channel.cmd <= cmd;
        end
    end

    // read data in the cycle after the read strobe
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata <= 32'h00000000;
        end else if (rd) begin
            rdata <= 32'h00000000;
            case (addr)
                `PIS_OFF_CTRL: rdata <= {24'h000000, skip_cycle_enable, 1'b0, tim_en_reg, ang_en_reg, mode_reg};
                `PIS_OFF_ANGLE: rdata <= {22'h000000, injection_start_angle};
                `PIS_OFF_DELAY: rdata <= {16'h0000, delay_us_reg};
                `PIS_OFF_SKIP: rdata <= {16'h0000, act_clamped, skip_period_length};
                `PIS_OFF_RPM: rdata <= {16'h0000, rpm_reg};
                `PIS_OFF_STATUS: rdata <= {24'h000000, cmd, busy};
                default: begin
                    for (int i = 0; i < 4; i++) begin
                        if (bank_hit(addr, `PIS_OFF_TOP0, 2'(i))) rdata <= {22'h000000, top_dead_centre[i]};
                        if (bank_hit(addr, `PIS_OFF_DUR0, 2'(i))) rdata <= {16'h0000, dur_us_reg[i]};
                        if (bank_hit(addr, `PIS_OFF_DEG0, 2'(i))) rdata <= {16'h0000, crank_angle_degrees[i]};
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    mode_angle_ignores_a: assert property (@(posedge clk) disable iff (!rst_b)
        (mode_reg == PIS_MODE_ANGLE && angle_hit_vec == 4'h0) |-> start == 4'h0)
        else $error("start without angle hit in angle mode");
    clamp_range_a: assert property (@(posedge clk) disable iff (!rst_b)
        act_clamped >= 8'h01 && act_clamped <= skip_period_length)
        else $error("active count out of range");
    period_min_a: assert property (@(posedge clk) disable iff (!rst_b)
        skip_period_length != 8'h00)
        else $error("period zero");
    skip_count_a: assert property (@(posedge clk) disable iff (!rst_b)
        skip_cycle_enable[0] |-> skip_cnt_reg[0] < skip_period_length)
        else $error("skip counter beyond period");
    trig_once_a: assert property (@(posedge clk) disable iff (!rst_b)
        manual_single_trigger[0] |=> !manual_single_trigger[0] || $past(wr))
        else $error("trigger held");
    off_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
        (mode_reg == PIS_MODE_TIME && !tim_en_reg && !$past(tim_en_reg, 2)) |-> cmd == 4'h0)
        else $error("command with enable off");
    out_follow_a: assert property (@(posedge clk) disable iff (!rst_b)
        ##1 port_injector_channel.cmd == $past(cmd))
        else $error("output does not follow command");
    angle_off_a: assert property (@(posedge clk) disable iff (!rst_b)
        (mode_reg == PIS_MODE_ANGLE && !ang_en_reg && $stable(mode_reg) && !$past(ang_en_reg)) |-> cmd == 4'h0)
        else $error("angle command with enable off");
    time_ignores_a: assert property (@(posedge clk) disable iff (!rst_b)
        (mode_reg == PIS_MODE_TIME && manual_single_trigger == 4'h0 && !trig_rise) |-> start == 4'h0)
        else $error("start without trigger in time mode");
    skip_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
        (mode_reg == PIS_MODE_ANGLE && skip_cycle_enable[0] && skip_cnt_reg[0] >= act_clamped) |-> !drive_en[0])
        else $error("suppressed cycle not masked");
    skip_wrap_a: assert property (@(posedge clk) disable iff (!rst_b)
        (skip_cycle_enable[0] && cycle_start && skip_cnt_reg[0] + 8'h01 >= skip_period_length)
        |=> skip_cnt_reg[0] == 8'h00)
        else $error("skip period did not restart");
    rise_off_a: assert property (@(posedge clk) disable iff (!rst_b)
        (mode_reg == PIS_MODE_TIME && !tim_en_reg) |=> (cmd & ~$past(cmd)) == 4'h0)
        else $error("time command rose with enable off");
    time_off_run_a: assert property (@(posedge clk) disable iff (!rst_b)
        (mode_reg == PIS_MODE_TIME && !tim_en_reg && start[2] && !busy[2]) |=> busy[2] && !cmd[2])
        else $error("disabled time slot not timed");
    angle_off_run_a: assert property (@(posedge clk) disable iff (!rst_b)
        (mode_reg == PIS_MODE_ANGLE && !ang_en_reg && start[3] && !busy[3]) |=> busy[3] && !cmd[3])
        else $error("disabled angle slot not timed");
    trig_launch_a: assert property (@(posedge clk) disable iff (!rst_b)
        (mode_reg == PIS_MODE_TIME && trig_rise && busy == 4'h0) |=> busy == 4'hF)
        else $error("trigger did not launch all channels");
    angle_launch_a: assert property (@(posedge clk) disable iff (!rst_b)
        (mode_reg == PIS_MODE_ANGLE && angle_hit_vec[0] && !busy[0]) |=> busy[0])
        else $error("angle hit did not launch channel");
    fire_c: cover property (@(posedge clk) disable iff (!rst_b) port_injector_channel.cmd[0]);
    manual_c: cover property (@(posedge clk) disable iff (!rst_b) manual_single_trigger[1] ##[1:100] cmd[1]);
    skip_c: cover property (@(posedge clk) disable iff (!rst_b) skip_cycle_enable[2] && skip_cnt_reg[2] >= act_clamped);
    trig_c: cover property (@(posedge clk) disable iff (!rst_b) trig_rise && mode_reg == PIS_MODE_TIME);
    wrap_c: cover property (@(posedge clk) disable iff (!rst_b) cycle_start && skip_cnt_reg[0] == 8'h02);
endmodule : pis_sequencer

/* pis_defines.svh */
`ifndef PIS_DEFINES_SVH
`define PIS_DEFINES_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define PIS_OFF_CTRL 8'h00
`define PIS_OFF_ANGLE 8'h04
`define PIS_OFF_DELAY 8'h08
`define PIS_OFF_SKIP 8'h0C
`define PIS_OFF_RPM 8'h10
`define PIS_OFF_TRIG 8'h14
`define PIS_OFF_STATUS 8'h18
`define PIS_OFF_TOP0 8'h20
`define PIS_OFF_DUR0 8'h30
`define PIS_OFF_DEG0 8'h40

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define PIS_CTRL_MODE_BIT 0
`define PIS_CTRL_ANG_EN_BIT 1
`define PIS_CTRL_TIM_EN_BIT 2
`define PIS_CTRL_SKIP_LSB 4
`define PIS_SKIP_ACT_LSB 8
`define PIS_RST_SKIP_PERIOD 8'h01
`define PIS_RST_SKIP_ACTIVE 8'h01

// ----------------------------------------------------------------------------
// timing: durations and delays are programmed in microseconds
// ----------------------------------------------------------------------------
`define PIS_CLK_MHZ 25
`define PIS_US_PER_MS 1000
`define PIS_CYC_PER_US `PIS_CLK_MHZ
`define PIS_DEG_PER_CYCLE 720

`endif

/* pis_pkg.sv */
package pis_pkg;
    // the four channels' commands towards the power stage
    typedef struct packed {
        logic [3:0] cmd;
    } pis_cmd_t;

    typedef enum logic {
        PIS_MODE_ANGLE,
        PIS_MODE_TIME
    } pis_mode_t;

    typedef enum logic [1:0] {
        PIS_IDLE,
        PIS_WAIT,
        PIS_PULSE
    } pis_state_t;
endpackage : pis_pkg

/* pis_cad_calc.sv */
`timescale 1ns/1ps
`include "pis_defines.svh"

// converts a microsecond duration into tenths of crank degrees:
// deg = ms * rpm * 6 / 1000, so tenths = us * rpm * 6 / 100000
module pis_deg_calc import pis_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // operands
    input wire logic [15:0] dur_us,
    input wire logic [15:0] rpm,
    // result
    output logic [15:0] deg_tenths
);
    logic [37:0] prod;

    // product of duration and speed
    assign prod = 38'(dur_us) * 38'(rpm) * 38'd6;

    // registered quotient, saturated
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            deg_tenths <= 16'h0000;
        end else if ((prod / 38'd100000) > 38'h000000FFFF) begin
            deg_tenths <= 16'hFFFF;
        end else begin
            deg_tenths <= 16'(prod / 38'd100000);
        end
    end
endmodule : pis_deg_calc

/* pis_channel.sv */
`timescale 1ns/1ps
`include "pis_defines.svh"

// one injector channel: waits a delay then holds the command for a duration
module pis_channel import pis_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // launch
    input wire logic start,
    input wire logic [23:0] delay_cyc,
    input wire logic [23:0] dur_cyc,
    input wire logic drive_en,
    // result
    output logic cmd,
    output logic busy
);
    pis_state_t state_reg;
    logic [23:0] cnt_reg;

    // sequence state; a start while busy is ignored
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg <= PIS_IDLE;
            cnt_reg <= 24'h000000;
            cmd <= 1'b0;
        end else begin
            case (state_reg)
                PIS_IDLE: begin
                    cmd <= 1'b0;
                    if (start) begin
                        cnt_reg <= delay_cyc;
                        state_reg <= PIS_WAIT;
                    end
                end
                PIS_WAIT: begin
                    if (cnt_reg == 24'h000000) begin
                        cnt_reg <= dur_cyc;
                        state_reg <= PIS_PULSE;
                        cmd <= drive_en && (dur_cyc != 24'h000000);
                    end else begin
                        cnt_reg <= cnt_reg - 24'h000001;
                    end
                end
                PIS_PULSE: begin
                    if (cnt_reg <= 24'h000001) begin
                        cmd <= 1'b0;
                        state_reg <= PIS_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 24'h000001;
                    end
                end
                default: begin
                    state_reg <= PIS_IDLE;
                    cmd <= 1'b0;
                end
            endcase
        end
    end

    assign busy = (state_reg != PIS_IDLE);
endmodule : pis_channel

/* pis_stage_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// power stage model: counts command pulses and measures their width
// ----------------------------------------------------------------------------
module pis_stage_model import pis_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // commands from the sequencer
    input wire pis_cmd_t drive,
    // observed pulses, eight bits of count and sixteen of width per channel
    output logic [31:0] pulse_count,
    output logic [63:0] last_width
);
    logic [3:0] prev_reg;
    logic [15:0] run_reg [4];

    // width is the number of edges a command is seen active
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prev_reg <= 4'h0;
            pulse_count <= 32'h0000_0000;
            last_width <= 64'h0;
            for (int i = 0; i < 4; i++) begin
                run_reg[i] <= 16'h0000;
            end
        end else begin
            prev_reg <= drive.cmd;
            for (int i = 0; i < 4; i++) begin
                if (drive.cmd[i]) begin
                    run_reg[i] <= run_reg[i] + 16'h0001;
                end else if (prev_reg[i]) begin
                    pulse_count[8*i +: 8] <= pulse_count[8*i +: 8] + 8'h01;
                    last_width[16*i +: 16] <= run_reg[i];
                    run_reg[i] <= 16'h0000;
                end
            end
        end
    end
endmodule : pis_stage_model

/* pis_sequencer_bench.sv */
`timescale 1ns/1ps
`include "pis_defines.svh"

module pis_sequencer_bench import pis_pkg::*;;
    // ------------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [9:0] crank_angle = 10'h000;
    logic cycle_start = 1'b0;
    logic [15:0] engine_rpm = 16'h03E8;
    logic trigger_event = 1'b0;
    pis_cmd_t port_injector_channel;
    logic [31:0] pulse_count, base_count, seen, trig_cyc;
    logic [63:0] last_width;
    logic [31:0] cyc = 32'h0;
    logic [31:0] rise_cyc [4];
    logic [9:0] rise_ang [4];
    logic [3:0] prev_cmd = 4'h0;
    int miscompares = 0;
    int check_count = 0;

    // 25 MHz clock
    always #20 clk = ~clk;

    pis_sequencer pis_sequencer_inst (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .crank_angle(crank_angle), .cycle_start(cycle_start), .engine_rpm(engine_rpm),
        .trigger_event(trigger_event), .port_injector_channel(port_injector_channel));
    pis_stage_model pis_stage_model_inst (.clk(clk), .rst_b(rst_b), .drive(port_injector_channel),
        .pulse_count(pulse_count), .last_width(last_width));

    // note the cycle and crank angle at which each command rises
    always @(posedge clk) begin
        cyc <= cyc + 32'h1;
        prev_cmd <= port_injector_channel.cmd;
        for (int i = 0; i < 4; i++) begin
            if (port_injector_channel.cmd[i] === 1'b1 && !prev_cmd[i]) begin
                rise_cyc[i] <= cyc;
                rise_ang[i] <= crank_angle;
            end
        end
    end

    // ------------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------------
    task check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask : check

    task wrap_up;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    task reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_write

    // read data is loaded in the cycle after the strobe and holds until the next read
    task reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask : reg_read

    task idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    // poll the busy bits, bounded
    task wait_idle;
        logic [31:0] s;
        int k;
        s = 32'hF;
        idle(4);
        for (k = 0; k < 400 && s[3:0] !== 4'h0; k++) begin
            reg_read(`PIS_OFF_STATUS, s);
        end
        if (k == 400) begin
            miscompares++;
            wrap_up();
        end
        idle(4);
    endtask : wait_idle

    // run whole engine cycles, angle one degree per clock
    task sweep(input int n);
        for (int c = 0; c < n; c++) begin
            for (int a = 0; a < 720; a++) begin
                @(posedge clk);
                crank_angle <= a[9:0];
                cycle_start <= (a == 0);
            end
        end
        wait_idle();
    endtask : sweep

    task pulse_trigger;
        @(posedge clk);
        trigger_event <= 1'b1;
        trig_cyc = cyc;
        idle(3);
        trigger_event <= 1'b0;
    endtask : pulse_trigger

    task snap;
        base_count = pulse_count;
    endtask : snap

    task check_delta(input int ch, input logic [7:0] exp);
        logic [7:0] d;
        d = pulse_count[8*ch +: 8] - base_count[8*ch +: 8];
        check({24'h0, d}, {24'h0, exp});
    endtask : check_delta

    task check_range(input int v, input int lo, input int hi);
        check({31'h0, (v >= lo && v <= hi)}, 32'h1);
    endtask : check_range

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        idle(12);
        rst_b <= 1'b1;
        reg_read(`PIS_OFF_SKIP, seen);
        check(seen, 32'h0101);
        reg_read(`PIS_OFF_CTRL, seen);
        check(seen, 32'h0);
        reg_read(8'hFC, seen);
        check(seen, 32'h0);
        reg_read(`PIS_OFF_RPM, seen);
        check(seen, 32'h03E8);
        reg_write(`PIS_OFF_SKIP, 32'h0503);
        reg_read(`PIS_OFF_SKIP, seen);
        check(seen, 32'h0303);
        reg_write(`PIS_OFF_SKIP, 32'h0000);
        reg_read(`PIS_OFF_SKIP, seen);
        check(seen, 32'h0101);
        $display("test reset and skip clamp done");
        // two milliseconds at 1000 then 3000 rpm: 12.0 then 36.0 degrees
        reg_write(`PIS_OFF_DUR0, 32'h07D0);
        idle(4);
        reg_read(`PIS_OFF_DEG0, seen);
        check(seen, 32'h0078);
        engine_rpm <= 16'h0BB8;
        idle(4);
        reg_read(`PIS_OFF_DEG0, seen);
        check(seen, 32'h0168);
        engine_rpm <= 16'h03E8;
        $display("test degree duration done");
        // channel i: top centre 100+180i, duration i+1 us; delay 2 us, advance 10
        for (int i = 0; i < 4; i++) begin
            reg_write(`PIS_OFF_TOP0 + 8'(4 * i), 32'(100 + 180 * i));
            reg_write(`PIS_OFF_DUR0 + 8'(4 * i), 32'(i + 1));
        end
        reg_write(`PIS_OFF_DELAY, 32'h2);
        reg_write(`PIS_OFF_ANGLE, 32'hA);
        reg_write(`PIS_OFF_CTRL, 32'h07);
        snap();
        reg_write(`PIS_OFF_TRIG, 32'h2);
        wait_idle();
        for (int i = 0; i < 4; i++) begin
            check_delta(i, (i == 1) ? 8'h01 : 8'h00);
        end
        check({16'h0, last_width[31:16]}, 32'h32);
        snap();
        pulse_trigger();
        wait_idle();
        for (int i = 0; i < 4; i++) begin
            check_delta(i, 8'h01);
            check({16'h0, last_width[16*i +: 16]}, 32'h19 * (i + 1));
            check_range(int'(rise_cyc[i] - trig_cyc), 50, 60);
        end
        snap();
        sweep(1);
        for (int i = 0; i < 4; i++) begin
            check_delta(i, 8'h00);
        end
        reg_write(`PIS_OFF_CTRL, 32'h01);
        snap();
        pulse_trigger();
        idle(20);
        reg_read(`PIS_OFF_STATUS, seen);
        check(seen & 32'hFF, 32'h0F);
        wait_idle();
        for (int i = 0; i < 4; i++) begin
            check_delta(i, 8'h00);
        end
        $display("test time mode done");
        reg_write(`PIS_OFF_CTRL, 32'h02);
        snap();
        sweep(1);
        for (int i = 0; i < 4; i++) begin
            check_delta(i, 8'h01);
            check({16'h0, last_width[16*i +: 16]}, 32'h19 * (i + 1));
            check_range(int'(rise_ang[i]) - (90 + 180 * i), 0, 6);
        end
        snap();
        pulse_trigger();
        wait_idle();
        for (int i = 0; i < 4; i++) begin
            check_delta(i, 8'h00);
        end
        reg_write(`PIS_OFF_CTRL, 32'h00);
        snap();
        sweep(1);
        for (int i = 0; i < 4; i++) begin
            check_delta(i, 8'h00);
        end
        $display("test angle mode done");
        // period 3, two active: six cycles give four pulses on channel 0
        reg_write(`PIS_OFF_SKIP, 32'h0203);
        reg_write(`PIS_OFF_CTRL, 32'h12);
        snap();
        sweep(6);
        for (int i = 0; i < 4; i++) begin
            check_delta(i, (i == 0) ? 8'h04 : 8'h06);
        end
        $display("test skip pattern done");
        wrap_up();
    end
endmodule : pis_sequencer_bench
